// ===== hw/pmic_pkg.sv
// package: power-mode and interrupt controller constants
package pmic_pkg;
  // operating modes
  typedef enum logic [2:0] {
    full_run_state,
    sleep_level_a,
    sleep_level_b,
    sleep_level_c,
    sleep_level_d,
    sleep_level_deep
  } pmic_mode_t;

  // register offsets (byte addresses on the plain port)
  localparam logic [3:0] OFS_IE1      = 4'h0;
  localparam logic [3:0] OFS_IFG1     = 4'h2;
  localparam logic [3:0] OFS_MODE_REQ = 4'h8;
  localparam logic [3:0] OFS_STATUS   = 4'h9;

  // enable register field positions
  localparam int BIT_WDT_IE  = 0;
  localparam int BIT_OF_IE   = 1;
  localparam int BIT_NMI_IE  = 4;
  localparam int BIT_ACCV_IE = 5;
  // flag register field positions
  localparam int BIT_WDT_F  = 0;
  localparam int BIT_OF_F   = 1;
  localparam int BIT_POR_F  = 2;
  localparam int BIT_RST_F  = 3;
  localparam int BIT_NMI_F  = 4;

  // reset values
  localparam logic [7:0] IE1_RESET      = 8'h00;
  localparam logic [7:0] IFG1_PUC_SET   = 8'h02;
  localparam logic [7:0] IFG1_POR_VALUE = 8'h04;

  // vector table
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_NMI   = 16'hFFFC;
  localparam logic [15:0] VEC_COMP  = 16'hFFF6;
  localparam logic [15:0] VEC_WDT   = 16'hFFF4;
  localparam logic [15:0] VEC_TCC0  = 16'hFFF2;
  localparam logic [15:0] VEC_TCC1  = 16'hFFF0;
  localparam logic [15:0] VEC_CONV  = 16'hFFEA;
  localparam logic [15:0] VEC_SER   = 16'hFFE8;
  localparam logic [15:0] VEC_PORT1 = 16'hFFE4;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [4:0]  PRIO_RESET  = 5'h1F;

  // fetch address map
  localparam logic [15:0] PERIPH_TOP = 16'h01FF;
  localparam logic [15:0] RAM_LO     = 16'h0200;
  localparam logic [15:0] RAM_HI     = 16'h027F;
  localparam logic [15:0] INFO_LO    = 16'h1000;
  localparam logic [15:0] INFO_HI    = 16'h10FF;
  localparam logic [15:0] CODE_LO    = 16'hF800;

  // cycles from vector request to accept
  localparam int BOOT_WAIT_CYCLES = 1;
endpackage

// ===== hw/pmic_top.sv
// power-mode sequencer, clock gating and interrupt vector selector
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none

module pmic_top (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        power_up_clear,
  input  wire logic        pin_reset_event,
  input  wire logic        watchdog_reset_event,
  input  wire logic        flash_key_violation_flag,
  input  wire logic        pin_nmi_event,
  input  wire logic        osc_fault_event,
  input  wire logic        flash_access_violation_flag,
  input  wire logic        comparator_flag,
  input  wire logic        watchdog_flag,
  input  wire logic        capture_compare_flag,
  input  wire logic        timer_overflow_flag,
  input  wire logic        converter_done_flag,
  input  wire logic        serial_unit_flag,
  input  wire logic        serial_start_cond_flag,
  input  wire logic [7:0]  port1_pin_flags,
  input  wire logic        global_irq_enable,
  input  wire logic        dco_used_in_run,
  input  wire logic        irq_accept,
  input  wire logic        irq_return,
  input  wire logic [15:0] fetch_addr,
  input  wire logic        fetch_valid,
  input  wire logic [15:0] reset_vector_word,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [7:0]       reg_rdata,
  output logic             cpu_run,
  output logic             main_clk_en,
  output logic             peripheral_fast_clock_en,
  output logic             aux_clk_en,
  output logic             tunable_oscillator_en,
  output logic             crystal_en,
  output logic             irq_request,
  output logic [15:0]      irq_vector,
  output logic             reset_request
);

  typedef struct packed {
    pmic_pkg::pmic_mode_t mode;
    pmic_pkg::pmic_mode_t saved;
    logic                 in_handler;
    logic                 booted;
    logic [7:0]           ie1;
    logic                 wdt_f;
    logic                 of_f;
    logic                 por_f;
    logic                 rst_f;
    logic                 nmi_f;
    logic [7:0]           rdata;
    logic                 run;
    logic                 mclk;
    logic                 fclk;
    logic                 aclk;
    logic                 tunable_oscillator;
    logic                 xtal;
    logic                 irq;
    logic [15:0]          vec;
    logic                 rst_req;
  } pmic_state_t;

  pmic_state_t st_reg;
  pmic_state_t st_next;
  logic        nmi_pend;
  logic        mask_ok;
  logic [15:0] pick_vec;
  logic        pick_any;

  // single decode of a bus hit, used by writes; reads decode reg_addr in their own case
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  // fetch legality: only ram, info flash, main code and the vector area
  function automatic logic fetch_bad(input logic [15:0] a);
    logic ok;
    ok = (a >= pmic_pkg::RAM_LO && a <= pmic_pkg::RAM_HI) ||
         (a >= pmic_pkg::INFO_LO && a <= pmic_pkg::INFO_HI) ||
         (a >= pmic_pkg::CODE_LO);
    fetch_bad = (a <= pmic_pkg::PERIPH_TOP) || !ok;
  endfunction

  // nmi group ignores the global enable, each source has its own enable
  assign nmi_pend = (st_reg.nmi_f & st_reg.ie1[pmic_pkg::BIT_NMI_IE]) |
                    (st_reg.of_f & st_reg.ie1[pmic_pkg::BIT_OF_IE]) |
                    (flash_access_violation_flag & st_reg.ie1[pmic_pkg::BIT_ACCV_IE]);
  assign mask_ok  = global_irq_enable;

  // fixed priority: higher vector word first; unused words never chosen
  always_comb begin
    pick_any = 1'b1;
    if (nmi_pend) begin
      pick_vec = pmic_pkg::VEC_NMI;
    end else if (mask_ok && comparator_flag) begin
      pick_vec = pmic_pkg::VEC_COMP;
    end else if (mask_ok && watchdog_flag && st_reg.ie1[pmic_pkg::BIT_WDT_IE]) begin
      pick_vec = pmic_pkg::VEC_WDT;
    end else if (mask_ok && capture_compare_flag) begin
      pick_vec = pmic_pkg::VEC_TCC0;
    end else if (mask_ok && timer_overflow_flag) begin
      pick_vec = pmic_pkg::VEC_TCC1;
    end else if (mask_ok && converter_done_flag) begin
      pick_vec = pmic_pkg::VEC_CONV;
    end else if (mask_ok && (serial_unit_flag || serial_start_cond_flag)) begin
      pick_vec = pmic_pkg::VEC_SER;
    end else if (mask_ok && (|port1_pin_flags)) begin
      pick_vec = pmic_pkg::VEC_PORT1;
    end else begin
      pick_any = 1'b0;
      pick_vec = pmic_pkg::VEC_RESET;
    end
  end

  // next-state logic for modes, flags, registers and outputs
  always_comb begin
    logic rst_evt;
    rst_evt = pin_reset_event | watchdog_reset_event | flash_key_violation_flag |
              (fetch_valid & fetch_bad(fetch_addr));
    st_next = st_reg;
    // flag sets from hardware; second-class flags survive power-up clear
    if (pin_reset_event) begin
      st_next.rst_f = 1'b1;
    end
    if (watchdog_reset_event || flash_key_violation_flag) begin
      st_next.wdt_f = 1'b1;
    end
    if (power_up_clear) begin
      st_next.ie1  = pmic_pkg::IE1_RESET;
      st_next.nmi_f = 1'b0;
      st_next.of_f = pmic_pkg::IFG1_PUC_SET[pmic_pkg::BIT_OF_F];
      st_next.mode = pmic_pkg::full_run_state;
      st_next.in_handler = 1'b0;
    end
    // register writes; only assigned bits exist
    if (reg_write && hit(reg_addr, pmic_pkg::OFS_IE1)) begin
      st_next.ie1 = reg_wdata & 8'h33;
    end
    if (reg_write && hit(reg_addr, pmic_pkg::OFS_IFG1)) begin
      st_next.wdt_f = reg_wdata[pmic_pkg::BIT_WDT_F] | watchdog_reset_event | flash_key_violation_flag;
      st_next.of_f  = reg_wdata[pmic_pkg::BIT_OF_F] | osc_fault_event;
      st_next.por_f = reg_wdata[pmic_pkg::BIT_POR_F];
      st_next.rst_f = reg_wdata[pmic_pkg::BIT_RST_F] | pin_reset_event;
      st_next.nmi_f = reg_wdata[pmic_pkg::BIT_NMI_F] | pin_nmi_event;
    end
    // event sets win over clears
    if (osc_fault_event) begin
      st_next.of_f = 1'b1;
    end
    if (pin_nmi_event) begin
      st_next.nmi_f = 1'b1;
    end
    if (reg_write && hit(reg_addr, pmic_pkg::OFS_MODE_REQ) && !st_reg.in_handler &&
        reg_wdata[2:0] <= 3'h5) begin
      st_next.mode = pmic_pkg::pmic_mode_t'(reg_wdata[2:0]);
    end
    // erased reset vector: park in deepest sleep right after power-up
    if (!st_reg.booted) begin
      st_next.booted = 1'b1;
      if (reset_vector_word == pmic_pkg::ERASED_WORD) begin
        st_next.mode = pmic_pkg::sleep_level_deep;
      end
    end
    // wake on accept, restore saved level on return
    if (irq_accept && !st_reg.in_handler) begin
      st_next.saved = st_reg.mode;
      st_next.mode = pmic_pkg::full_run_state;
      st_next.in_handler = 1'b1;
    end else if (irq_return && st_reg.in_handler) begin
      st_next.mode = st_reg.saved;
      st_next.in_handler = 1'b0;
    end
    // read data stands one cycle after the strobe
    st_next.rdata = 8'h00;
    if (reg_read) begin
      unique case (reg_addr)
        pmic_pkg::OFS_IE1:      st_next.rdata = st_reg.ie1;
        pmic_pkg::OFS_IFG1:     st_next.rdata = {3'b000, st_reg.nmi_f, st_reg.rst_f, st_reg.por_f,
                                                 st_reg.of_f, st_reg.wdt_f};
        pmic_pkg::OFS_MODE_REQ: st_next.rdata = {5'h00, st_reg.mode};
        pmic_pkg::OFS_STATUS:   st_next.rdata = {7'h00, st_reg.in_handler};
        default:                st_next.rdata = 8'h00;
      endcase
    end
    // clock gating by mode
    unique case (st_next.mode)
      pmic_pkg::full_run_state: {st_next.run, st_next.mclk, st_next.fclk, st_next.aclk,
                                 st_next.tunable_oscillator, st_next.xtal} = 6'b111111;
      pmic_pkg::sleep_level_a:  {st_next.run, st_next.mclk, st_next.fclk, st_next.aclk,
                                 st_next.tunable_oscillator, st_next.xtal} = 6'b001111;
      pmic_pkg::sleep_level_b:  {st_next.run, st_next.mclk, st_next.fclk, st_next.aclk,
                                 st_next.tunable_oscillator, st_next.xtal} = {4'b0011, dco_used_in_run, 1'b1};
      pmic_pkg::sleep_level_c:  {st_next.run, st_next.mclk, st_next.fclk, st_next.aclk,
                                 st_next.tunable_oscillator, st_next.xtal} = 6'b000111;
      pmic_pkg::sleep_level_d:  {st_next.run, st_next.mclk, st_next.fclk, st_next.aclk,
                                 st_next.tunable_oscillator, st_next.xtal} = 6'b000101;
      default:                  {st_next.run, st_next.mclk, st_next.fclk, st_next.aclk,
                                 st_next.tunable_oscillator, st_next.xtal} = 6'b000000;
    endcase
    // vector selection; reset outranks everything
    st_next.rst_req = rst_evt;
    if (rst_evt) begin
      st_next.irq = 1'b1;
      st_next.vec = pmic_pkg::VEC_RESET;
    end else begin
      st_next.irq = pick_any && !st_next.in_handler;
      st_next.vec = pick_vec;
    end
  end

  // state register; power-on reset loads every class
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.mode <= pmic_pkg::full_run_state;
      st_reg.saved <= pmic_pkg::full_run_state;
      st_reg.of_f <= pmic_pkg::IFG1_POR_VALUE[pmic_pkg::BIT_OF_F];
      st_reg.por_f <= pmic_pkg::IFG1_POR_VALUE[pmic_pkg::BIT_POR_F];
      // reset mode is full run, so its clock enables already match it
      {st_reg.run, st_reg.mclk, st_reg.fclk, st_reg.aclk, st_reg.tunable_oscillator, st_reg.xtal} <= 6'b111111;
      st_reg.vec <= pmic_pkg::VEC_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign cpu_run = st_reg.run;
  assign main_clk_en = st_reg.mclk;
  assign peripheral_fast_clock_en = st_reg.fclk;
  assign aux_clk_en = st_reg.aclk;
  assign tunable_oscillator_en = st_reg.tunable_oscillator;
  assign crystal_en = st_reg.xtal;
  assign irq_request = st_reg.irq;
  assign irq_vector = st_reg.vec;
  assign reset_request = st_reg.rst_req;

  // checks
  a_deep_clocks_off: assert property (@(posedge clk) disable iff (reset)
    st_reg.mode == pmic_pkg::sleep_level_deep |-> !aux_clk_en && !crystal_en && !main_clk_en)
    else $error("deep sleep left a clock running");
  a_run_all_on: assert property (@(posedge clk) disable iff (reset)
    st_reg.mode == pmic_pkg::full_run_state |-> cpu_run && main_clk_en && aux_clk_en)
    else $error("run mode lacks a clock");
  a_level_a_gate: assert property (@(posedge clk) disable iff (reset)
    st_reg.mode == pmic_pkg::sleep_level_a |-> !main_clk_en && peripheral_fast_clock_en)
    else $error("level a gating wrong");
  a_level_d_gate: assert property (@(posedge clk) disable iff (reset)
    st_reg.mode == pmic_pkg::sleep_level_d |-> !tunable_oscillator_en && aux_clk_en)
    else $error("level d gating wrong");
  a_wake_restore: assert property (@(posedge clk) disable iff (reset)
    irq_accept && !st_reg.in_handler && !power_up_clear |=> cpu_run && st_reg.saved == $past(st_reg.mode))
    else $error("wake did not save mode");
  a_reset_vec: assert property (@(posedge clk) disable iff (reset)
    pin_reset_event |=> irq_vector == pmic_pkg::VEC_RESET && reset_request)
    else $error("reset did not win");
  a_bad_fetch: assert property (@(posedge clk) disable iff (reset)
    fetch_valid && fetch_addr <= pmic_pkg::PERIPH_TOP |=> reset_request)
    else $error("peripheral fetch not reset");
  a_nmi_set_wins: assert property (@(posedge clk) disable iff (reset)
    pin_nmi_event |=> st_reg.nmi_f)
    else $error("nmi flag lost");
  c_wake: cover property (@(posedge clk) disable iff (reset)
    st_reg.mode == pmic_pkg::sleep_level_c ##1 irq_accept);
  c_return: cover property (@(posedge clk) disable iff (reset) irq_return && st_reg.in_handler);
  c_deep: cover property (@(posedge clk) disable iff (reset) st_reg.mode == pmic_pkg::sleep_level_deep);

endmodule

`default_nettype wire

// ===== verification/pmic_cpu_model.sv
// partner model: cpu core that takes vectors and returns from handlers
`timescale 1ns/1ns
`default_nettype none
module pmic_cpu_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ack_en,
  input  wire logic        irq_request,
  input  wire logic [15:0] irq_vector,
  output var logic         irq_accept,
  output var logic         irq_return,
  output var logic [15:0]  pc_loaded
);
  // one request at a time, short handler, no nesting like the real core
  initial begin
    irq_accept = 1'b0;
    irq_return = 1'b0;
    pc_loaded  = 16'h0000;
    forever begin
      @(posedge clk);
      if (!reset && ack_en && irq_request === 1'b1) begin
        irq_accept <= 1'b1;
        pc_loaded  <= irq_vector;
        @(posedge clk);
        irq_accept <= 1'b0;
        repeat (4) @(posedge clk);
        irq_return <= 1'b1;
        @(posedge clk);
        irq_return <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench for the power-mode and interrupt controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fails++; \
  $display("BAD %s expected %h seen %h", nm, ex, got); end end
module testbench;
  logic        clk, reset, power_up_clear, pin_reset_event, watchdog_reset_event, flash_key_violation_flag;
  logic        pin_nmi_event, osc_fault_event, flash_access_violation_flag, global_irq_enable, dco_used_in_run;
  logic        irq_accept, irq_return, fetch_valid, reg_write, reg_read, cpu_run, main_clk_en, ack_en;
  logic        peripheral_fast_clock_en, aux_clk_en, tunable_oscillator_en, crystal_en, irq_request, reset_request;
  logic [6:0]  pf;
  logic [7:0]  port1_pin_flags, reg_wdata, reg_rdata, d;
  logic [3:0]  reg_addr;
  logic [15:0] fetch_addr, reset_vector_word, irq_vector, pc_loaded;
  logic [5:0]  ce;
  int          fails, n_tests;
  // clock enables per mode: cpu, main, fast, aux, oscillator, crystal
  localparam logic [5:0]  MODE_CE [6] = '{6'h3F, 6'h0F, 6'h0F, 6'h07, 6'h05, 6'h00};
  localparam logic [15:0] PF_VEC [7] = '{pmic_pkg::VEC_COMP, pmic_pkg::VEC_WDT, pmic_pkg::VEC_TCC0,
    pmic_pkg::VEC_TCC1, pmic_pkg::VEC_CONV, pmic_pkg::VEC_SER, pmic_pkg::VEC_SER};
  localparam int          NMI_BIT [3] = '{5, 4, 1};
  localparam logic [15:0] F_ADDR [6] = '{16'h0100, 16'h0300, 16'hF800, 16'h0200, 16'h1000, 16'h2000};
  localparam logic        F_BAD [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
  assign ce = {cpu_run, main_clk_en, peripheral_fast_clock_en, aux_clk_en, tunable_oscillator_en, crystal_en};
  pmic_top u_dut (.clk, .reset, .power_up_clear, .pin_reset_event, .watchdog_reset_event,
    .flash_key_violation_flag, .pin_nmi_event, .osc_fault_event, .flash_access_violation_flag,
    .comparator_flag(pf[0]), .watchdog_flag(pf[1]), .capture_compare_flag(pf[2]), .timer_overflow_flag(pf[3]),
    .converter_done_flag(pf[4]), .serial_unit_flag(pf[5]), .serial_start_cond_flag(pf[6]), .port1_pin_flags,
    .global_irq_enable, .dco_used_in_run, .irq_accept, .irq_return, .fetch_addr, .fetch_valid,
    .reset_vector_word, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .cpu_run, .main_clk_en,
    .peripheral_fast_clock_en, .aux_clk_en, .tunable_oscillator_en, .crystal_en, .irq_request, .irq_vector,
    .reset_request);
  pmic_cpu_model u_cpu (.clk, .reset, .ack_en, .irq_request, .irq_vector, .irq_accept, .irq_return, .pc_loaded);
  always #50 clk = ~clk;
  // sample one nanosecond past the edge so registered outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // one-cycle event: 0 pin reset, 1 watchdog, 2 key, 3 nmi, 4 osc fault, 5 fetch
  task automatic pulse(input int k, input logic [15:0] a);
    @(posedge clk);
    fetch_addr <= a;
    case (k)
      0: pin_reset_event <= 1'b1;
      1: watchdog_reset_event <= 1'b1;
      2: flash_key_violation_flag <= 1'b1;
      3: pin_nmi_event <= 1'b1;
      4: osc_fault_event <= 1'b1;
      default: fetch_valid <= 1'b1;
    endcase
    @(posedge clk);
    {pin_reset_event, watchdog_reset_event, flash_key_violation_flag, pin_nmi_event, osc_fault_event} <= '0;
    fetch_valid <= 1'b0;
    #1;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hang guard, well beyond the few hundred cycles the tests need
  initial begin
    #3000000;
    fails++;
    close_out();
  end
  initial begin
    {clk, power_up_clear, pin_reset_event, watchdog_reset_event, flash_key_violation_flag} = '0;
    {pin_nmi_event, osc_fault_event, flash_access_violation_flag, global_irq_enable, fetch_valid} = '0;
    {reg_write, reg_read, ack_en, pf, port1_pin_flags, reg_wdata, reg_addr, fetch_addr} = '0;
    {fails, n_tests} = '0;
    reset = 1'b1;
    dco_used_in_run = 1'b1;
    reset_vector_word = 16'hF800;
    tick(2);
    reset <= 1'b0;
    tick(2);
    `CHK("run clocks", 6'h3F, ce)
    rd(pmic_pkg::OFS_IE1);
    `CHK("ie1 reset", 8'h00, d)
    rd(pmic_pkg::OFS_IFG1);
    `CHK("ifg1 reset", 8'h04, d)
    rd(4'h4);
    `CHK("unmapped", 8'h00, d)
    done("reset");
    for (int m = 0; m < 6; m++) begin
      wr(pmic_pkg::OFS_MODE_REQ, 8'(m));
      tick(1);
      `CHK("mode clocks", MODE_CE[m], ce)
    end
    wr(pmic_pkg::OFS_MODE_REQ, 8'h03);
    wr(pmic_pkg::OFS_MODE_REQ, 8'h06);
    tick(1);
    `CHK("bad mode", 6'h07, ce)
    @(posedge clk);
    dco_used_in_run <= 1'b0;
    wr(pmic_pkg::OFS_MODE_REQ, 8'h02);
    tick(1);
    `CHK("level b unused", 6'h0D, ce)
    @(posedge clk);
    dco_used_in_run <= 1'b1;
    tick(2);
    `CHK("level b used", 6'h0F, ce)
    done("modes");
    // wake from level d, run the handler, fall back asleep
    wr(pmic_pkg::OFS_MODE_REQ, 8'h04);
    @(posedge clk);
    global_irq_enable <= 1'b1;
    ack_en <= 1'b1;
    pf <= 7'h01;
    for (int i = 0; i < 20 && irq_accept !== 1'b1; i++) tick(1);
    @(posedge clk);
    pf <= '0;
    ack_en <= 1'b0;
    #1;
    `CHK("awake clocks", 6'h3F, ce)
    `CHK("loaded vector", pmic_pkg::VEC_COMP, pc_loaded)
    for (int i = 0; i < 20 && irq_return !== 1'b1; i++) tick(1);
    tick(2);
    `CHK("back asleep", 6'h05, ce)
    wr(pmic_pkg::OFS_MODE_REQ, 8'h00);
    done("wake");
    // sources i..6 pending with all port pins: the highest vector wins
    wr(pmic_pkg::OFS_IE1, 8'h01);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      pf <= 7'h7F << i;
      port1_pin_flags <= 8'hFF;
      tick(2);
      `CHK("priority vector", PF_VEC[i], irq_vector)
    end
    for (int b = 0; b < 8; b++) begin
      @(posedge clk);
      pf <= '0;
      port1_pin_flags <= 8'(1 << b);
      tick(2);
      `CHK("port1 vector", pmic_pkg::VEC_PORT1, irq_vector)
    end
    @(posedge clk);
    port1_pin_flags <= '0;
    tick(2);
    `CHK("idle request", 1'b0, irq_request)
    done("vectors");
    // nmi group with the global enable off
    @(posedge clk);
    global_irq_enable <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      if (k == 0) begin
        @(posedge clk);
        flash_access_violation_flag <= 1'b1;
      end else begin
        pulse(k + 2, 16'h0000);
      end
      tick(2);
      `CHK("nmi masked", 1'b0, irq_request)
      wr(pmic_pkg::OFS_IE1, 8'(1 << NMI_BIT[k]));
      tick(2);
      `CHK("nmi request", 1'b1, irq_request)
      `CHK("nmi vector", pmic_pkg::VEC_NMI, irq_vector)
      @(posedge clk);
      flash_access_violation_flag <= 1'b0;
      wr(pmic_pkg::OFS_IE1, 8'h00);
      wr(pmic_pkg::OFS_IFG1, 8'h00);
    end
    done("nmi");
    // only assigned bits exist; power-up clear spares the power-on class
    wr(pmic_pkg::OFS_IE1, 8'hFF);
    rd(pmic_pkg::OFS_IE1);
    `CHK("ie1 bits", 8'h33, d)
    wr(pmic_pkg::OFS_IFG1, 8'hFF);
    rd(pmic_pkg::OFS_IFG1);
    `CHK("ifg1 bits", 8'h1F, d)
    @(posedge clk);
    power_up_clear <= 1'b1;
    @(posedge clk);
    power_up_clear <= 1'b0;
    rd(pmic_pkg::OFS_IE1);
    `CHK("ie1 cleared", 8'h00, d)
    rd(pmic_pkg::OFS_IFG1);
    `CHK("ifg1 classes", 8'h0F, d)
    wr(pmic_pkg::OFS_IFG1, 8'h00);
    done("reset classes");
    for (int k = 0; k < 3; k++) begin
      pulse(k, 16'h0000);
      `CHK("reset event", 1'b1, reset_request)
      tick(1);
      `CHK("reset pulse end", 1'b0, reset_request)
      if (k == 0) begin
        rd(pmic_pkg::OFS_IFG1);
        `CHK("pin reset flag", 8'h08, d)
      end
    end
    for (int j = 0; j < 6; j++) begin
      pulse(5, F_ADDR[j]);
      `CHK("fetch reset", F_BAD[j], reset_request)
    end
    done("reset sources");
    // erased reset word sends the core straight to deep sleep
    @(posedge clk);
    reset <= 1'b1;
    reset_vector_word <= 16'hFFFF;
    tick(2);
    reset <= 1'b0;
    tick(3);
    `CHK("erased vector", 6'h00, ce)
    done("erased vector");
    close_out();
  end
endmodule
`default_nettype wire
